// ### rtl/quad_ser_regs.svh
// Purpose: register offsets, latch fields, reset values and timing figures
// Assumes: APB byte addresses, 32-bit data, one register per aligned word
// Notes:   included by the serializer path, the self-test generator and the bench
`ifndef QUAD_SER_REGS_SVH
`define QUAD_SER_REGS_SVH

// ==========================================================
// apb register offsets
`define REG_CHAN_STATUS    8'h00
`define REG_IRQ_STATUS     8'h04
`define REG_IRQ_MASK       8'h08
`define REG_CFG_WRITE      8'h0C

// ==========================================================
// apb config write fields
`define CFG_DATA_MSB       4
`define CFG_DATA_LSB       0
`define CFG_BANK_MSB       8
`define CFG_BANK_LSB       5

// ==========================================================
// latch bank map
`define BANKS_PER_CHAN     3
`define NUM_CHAN_BANKS     12
`define GLOBAL_BANK_FIRST  4'hC
`define GLOBAL_BANK_LAST   4'hE
`define BIT_GLOBAL_EN      0
`define BIT_CLK_SEL        1
`define BIT_HALF_RATE      2
`define BIT_SPEED_LSB      3
`define BIT_SPEED_MSB      4
`define BIT_DRV_PRIMARY    1
`define BIT_DRV_SECONDARY  2
`define BIT_SELF_TEST      1
`define BIT_PA_RESET       2

// ==========================================================
// latch bank and irq mask reset values
`define RST_BANK_RATE      5'h0B
`define RST_BANK_DRIVER    5'h01
`define RST_BANK_DYNAMIC   5'h05
`define RST_IRQ_MASK       4'h0

// ==========================================================
// characters and sequences
`define ERROR_CHAR         10'h278
`define LFSR_SEED          9'h1FF

// ==========================================================
// timing
`define MCLK_FREQ_MHZ      25
`define REENABLE_SETTLE_US 250

`endif

// ### rtl/quad_ser_pkg.sv
// Purpose: types shared by the serializer path
// Assumes: nothing
// Notes:   numeric constants live in quad_ser_regs.svh
package quad_ser_pkg;

    // ==========================================================
    // speed range latch decode
    typedef enum logic [1:0] {
        SPEED_LOW,
        SPEED_MID,
        SPEED_HIGH,
        SPEED_UNUSED
    } speed_range_t;

    // ==========================================================
    // character source of the transmit shifter
    typedef enum {
        SRC_DATA,
        SRC_ERROR,
        SRC_SELF_TEST
    } char_source_t;

endpackage : quad_ser_pkg

// ### rtl/phase_align_buffer.sv
// Purpose: phase-align buffer between capture ticks and character ticks
// Assumes: both ticks are one-cycle pulses on mclk
// Notes:   error is sticky until init
`timescale 1ns/1ps
`default_nettype none
module phase_align_buffer #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // control
    input  wire logic             init,
    // fill side
    input  wire logic             wr_tick,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    input  wire logic             rd_tick,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  overrun
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("phase_align_buffer depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      fill;
    logic             do_wr;
    logic             do_rd;

    // ==========================================================
    // pointers and fill level
    assign do_wr   = wr_tick && fill != (PW + 1)'(DEPTH);
    assign do_rd   = rd_tick && fill != '0;
    assign rd_data = mem[rd_ptr];

    always_ff @(posedge mclk) begin
        if (rst || init) begin
            wr_ptr <= PW'(DEPTH / 2);
            rd_ptr <= '0;
            fill   <= (PW + 1)'(DEPTH / 2);
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + (PW + 1)'(do_wr) - (PW + 1)'(do_rd);
        end
    end

    // ==========================================================
    // storage
    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // ==========================================================
    // sticky overrun
    // sticky overrun flag
    always_ff @(posedge mclk) begin
        if (rst || init) begin
            overrun <= 1'b0;
        end else if ((wr_tick && !do_wr) || (rd_tick && !do_rd)) begin
            overrun <= 1'b1;
        end
    end

endmodule : phase_align_buffer
`default_nettype wire

// ### rtl/self_test_lfsr.sv
// Purpose: self-test character generator, period 511 characters
// Assumes: step is a one-cycle pulse per character
// Notes:   seed is reloaded while disabled
`timescale 1ns/1ps
`default_nettype none
`include "quad_ser_regs.svh"
module self_test_lfsr (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // control
    input  wire logic       enable,
    input  wire logic       step,
    // character out
    output logic      [9:0] char_out
);
    logic [8:0] lfsr;

    // ==========================================================
    // nine-bit maximal sequence, one step per character
    // lfsr sequence
    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            lfsr <= `LFSR_SEED;
        end else if (step) begin
            lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
        end
    end

    assign char_out = {lfsr[8] ^ lfsr[4], lfsr};

endmodule : self_test_lfsr
`default_nettype wire

// ### rtl/quad_video_tx_serializer_path.sv
// Purpose: four-channel transmit path of a video serializer
// Assumes: clock pins are sampled on mclk and run far below it
// Notes:   one character takes ten mclk cycles on the serial outputs
`timescale 1ns/1ps
`default_nettype none
`include "quad_ser_regs.svh"
module quad_video_tx_serializer_path
    import quad_ser_pkg::*;
#(
    parameter int NUM_CH        = 4,
    parameter int CHAR_W        = 10,
    parameter int PA_DEPTH      = 4,
    parameter int SETTLE_CYCLES = `REENABLE_SETTLE_US * `MCLK_FREQ_MHZ
) (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // configuration pins
    input  wire logic                           config_write_strobe_n,
    input  wire logic [3:0]                     config_addr,
    input  wire logic [4:0]                     config_data,
    // channel inputs
    input  wire logic [NUM_CH-1:0]              channel_reference_clock,
    input  wire logic [NUM_CH-1:0]              tx_input_clock,
    input  wire logic [NUM_CH-1:0][CHAR_W-1:0]  tx_parallel_char_in,
    // channel outputs
    output logic      [NUM_CH-1:0]              phase_buffer_error,
    output logic      [NUM_CH-1:0]              char_rate_clock_out,
    output logic      [NUM_CH-1:0]              primary_serial_out,
    output logic      [NUM_CH-1:0]              secondary_serial_out,
    // interrupt
    output logic                                irq
);
    if (NUM_CH != 4 || CHAR_W != 10 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
    begin : g_bad_params
        $error("serializer path supports four 10-bit channels and a 16-bit settle count");
    end

    // ==========================================================
    // declarations
    logic [2:0]       wr_n_sync;
    logic [2:0][3:0]  addr_sync;
    logic [2:0][4:0]  data_sync;
    logic             pin_wr;
    logic             apb_setup;
    logic             apb_access;
    logic             addr_ok;
    logic             apb_cfg_wr;
    logic             cfg_wr;
    logic [3:0]       cfg_bank;
    logic [4:0]       cfg_val;
    logic             cfg_global;
    logic [4:0]       bank [`NUM_CHAN_BANKS];
    logic [`NUM_CHAN_BANKS-1:0] bank_hit;
    logic [NUM_CH-1:0] pa_init;
    logic [NUM_CH-1:0] self_test_on;
    logic [NUM_CH-1:0] powered;
    logic [NUM_CH-1:0] settling;
    logic [NUM_CH-1:0] speed_reserved;
    logic [NUM_CH-1:0] err_event;
    logic [NUM_CH-1:0] irq_status;
    logic [NUM_CH-1:0] irq_mask;
    logic [NUM_CH-1:0] irq_clear;
    logic [31:0]       next_prdata;

    function automatic logic [4:0] bank_reset(input int kind);
        logic [4:0] value;
        value = `RST_BANK_DYNAMIC;
        if (kind == 0) begin
            value = `RST_BANK_RATE;
        end else if (kind == 1) begin
            value = `RST_BANK_DRIVER;
        end
        return value;
    endfunction : bank_reset

    // ==========================================================
    // configuration pin synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_n_sync <= 3'h7;
            addr_sync <= '0;
            data_sync <= '0;
        end else begin
            wr_n_sync <= {wr_n_sync[1:0], config_write_strobe_n};
            addr_sync <= {addr_sync[1:0], config_addr};
            data_sync <= {data_sync[1:0], config_data};
        end
    end

    assign pin_wr = !wr_n_sync[1] && !wr_n_sync[2]
                    && addr_sync[1] == addr_sync[2] && data_sync[1] == data_sync[2];

    // ==========================================================
    // apb slave
    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign pready     = 1'b1;
    assign addr_ok    = paddr == `REG_CHAN_STATUS || paddr == `REG_IRQ_STATUS
                        || paddr == `REG_IRQ_MASK || paddr == `REG_CFG_WRITE;
    assign pslverr    = apb_access && !addr_ok;
    assign apb_cfg_wr = apb_access && pwrite && paddr == `REG_CFG_WRITE;

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `REG_CHAN_STATUS: begin
                next_prdata[3:0]   = phase_buffer_error;
                next_prdata[7:4]   = self_test_on;
                next_prdata[11:8]  = powered;
                next_prdata[15:12] = settling;
                next_prdata[19:16] = speed_reserved;
            end
            `REG_IRQ_STATUS: next_prdata[3:0] = irq_status;
            `REG_IRQ_MASK:   next_prdata[3:0] = irq_mask;
            default:         next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    // ==========================================================
    // interrupt status and mask
    assign irq_clear = (apb_access && pwrite && paddr == `REG_IRQ_STATUS)
                       ? pwdata[NUM_CH-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | err_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask <= `RST_IRQ_MASK;
        end else if (apb_access && pwrite && paddr == `REG_IRQ_MASK) begin
            irq_mask <= pwdata[NUM_CH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // configuration latch banks
    assign cfg_wr     = apb_cfg_wr || pin_wr;
    assign cfg_bank   = apb_cfg_wr ? pwdata[`CFG_BANK_MSB:`CFG_BANK_LSB] : addr_sync[2];
    assign cfg_val    = apb_cfg_wr ? pwdata[`CFG_DATA_MSB:`CFG_DATA_LSB] : data_sync[2];
    assign cfg_global = cfg_bank >= `GLOBAL_BANK_FIRST && cfg_bank <= `GLOBAL_BANK_LAST;

    always_comb begin
        for (int b = 0; b < `NUM_CHAN_BANKS; b++) begin
            bank_hit[b] = cfg_wr && (cfg_bank == 4'(b)
                          || (cfg_global && cfg_bank - `GLOBAL_BANK_FIRST
                              == 4'(b % `BANKS_PER_CHAN)
                              && bank[b][`BIT_GLOBAL_EN]));
        end
    end

    always_ff @(posedge mclk) begin
        for (int b = 0; b < `NUM_CHAN_BANKS; b++) begin
            if (rst) begin
                bank[b] <= bank_reset(b % `BANKS_PER_CHAN);
            end else if (bank_hit[b]) begin
                bank[b] <= cfg_global ? {cfg_val[4:1], bank[b][`BIT_GLOBAL_EN]} : cfg_val;
            end
        end
    end

    // ==========================================================
    // per-channel transmit path
    // four channels
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        logic [4:0]        rate_bank;
        logic [4:0]        drv_bank;
        logic [4:0]        dyn_bank;
        logic              clk_sel;
        logic              half_rate;
        logic              drv_primary;
        logic              drv_secondary;
        speed_range_t      speed;
        logic [2:0]        ref_sync;
        logic [2:0]        in_sync;
        logic [2:0][CHAR_W-1:0] char_sync;
        logic              ref_rise;
        logic              ref_fall;
        logic              in_rise;
        logic              char_tick;
        logic              cap_tick;
        logic [CHAR_W-1:0] cap_char;
        logic              use_buffer;
        logic [CHAR_W-1:0] buf_char;
        logic              buf_overrun;
        logic [CHAR_W-1:0] lfsr_char;
        char_source_t      source;
        logic [CHAR_W-1:0] next_char;
        logic [CHAR_W-1:0] shifter;
        logic [3:0]        bit_cnt;
        logic              err_prev;
        logic              powered_prev;
        logic [15:0]       settle_cnt;

        assign rate_bank     = bank[ch * `BANKS_PER_CHAN];
        assign drv_bank      = bank[ch * `BANKS_PER_CHAN + 1];
        assign dyn_bank      = bank[ch * `BANKS_PER_CHAN + 2];
        assign clk_sel       = rate_bank[`BIT_CLK_SEL];
        assign half_rate     = rate_bank[`BIT_HALF_RATE];
        assign speed         = speed_range_t'(rate_bank[`BIT_SPEED_MSB:`BIT_SPEED_LSB]);
        assign drv_primary   = drv_bank[`BIT_DRV_PRIMARY];
        assign drv_secondary = drv_bank[`BIT_DRV_SECONDARY];

        assign speed_reserved[ch] = speed == SPEED_LOW && half_rate;
        assign self_test_on[ch]   = dyn_bank[`BIT_SELF_TEST];
        assign powered[ch]        = drv_primary || drv_secondary;
        assign pa_init[ch]        = bank_hit[ch * `BANKS_PER_CHAN + 2]
                                    && !cfg_val[`BIT_PA_RESET];

        // ------------------------------------------------------
        // clock and data pin synchronisers
        always_ff @(posedge mclk) begin
            if (rst) begin
                ref_sync  <= '0;
                in_sync   <= '0;
                char_sync <= '0;
            end else begin
                ref_sync  <= {ref_sync[1:0], channel_reference_clock[ch]};
                in_sync   <= {in_sync[1:0], tx_input_clock[ch]};
                char_sync <= {char_sync[1:0], tx_parallel_char_in[ch]};
            end
        end

        assign ref_rise = ref_sync[1] && !ref_sync[2];
        assign ref_fall = !ref_sync[1] && ref_sync[2];
        assign in_rise  = in_sync[1] && !in_sync[2];

        assign char_tick = powered[ch] && (ref_rise || (half_rate && ref_fall));

        // ------------------------------------------------------
        // input register
        // capture clock select
        assign cap_tick = clk_sel ? char_tick : in_rise;

        always_ff @(posedge mclk) begin
            if (rst) begin
                cap_char <= '0;
            end else if (cap_tick && powered[ch]) begin
                cap_char <= char_sync[2];
            end
        end

        // ------------------------------------------------------
        // phase-align buffer
        // buffer in or bypassed
        assign use_buffer = !clk_sel;

        phase_align_buffer #(
            .WIDTH (CHAR_W),
            .DEPTH (PA_DEPTH)
        ) u_pa_buf (
            .mclk    (mclk),
            .rst     (rst),
            .init    (pa_init[ch] || !use_buffer || !powered[ch]),
            .wr_tick (in_rise && use_buffer && powered[ch]),
            .wr_data (char_sync[2]),
            .rd_tick (char_tick && use_buffer),
            .rd_data (buf_char),
            .overrun (buf_overrun)
        );

        always_ff @(posedge mclk) begin
            if (rst || pa_init[ch]) begin
                phase_buffer_error[ch] <= 1'b0;
            end else if (char_tick) begin
                phase_buffer_error[ch] <= use_buffer && buf_overrun;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                err_prev <= 1'b0;
            end else begin
                err_prev <= phase_buffer_error[ch];
            end
        end

        assign err_event[ch] = phase_buffer_error[ch] && !err_prev;

        // ------------------------------------------------------
        // self-test generator
        self_test_lfsr u_lfsr (
            .mclk     (mclk),
            .rst      (rst),
            .enable   (self_test_on[ch]),
            .step     (char_tick),
            .char_out (lfsr_char)
        );

        // ------------------------------------------------------
        // character source
        // data ignored in self-test
        always_comb begin
            if (self_test_on[ch]) begin
                source = SRC_SELF_TEST;
            end else if (phase_buffer_error[ch]) begin
                source = SRC_ERROR;
            end else begin
                source = SRC_DATA;
            end
            unique case (source)
                SRC_SELF_TEST: next_char = lfsr_char;
                SRC_ERROR:     next_char = `ERROR_CHAR;
                SRC_DATA:      next_char = use_buffer ? buf_char : cap_char;
            endcase
        end

        // ------------------------------------------------------
        // transmit shifter
        // lsb first shift
        always_ff @(posedge mclk) begin
            if (rst || !powered[ch]) begin
                shifter <= '0;
                bit_cnt <= 4'h9;
            end else if (char_tick) begin
                shifter <= next_char;
                bit_cnt <= 4'h0;
            end else begin
                shifter <= {1'b0, shifter[CHAR_W-1:1]};
                bit_cnt <= (bit_cnt == 4'h9) ? bit_cnt : bit_cnt + 4'h1;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst || !powered[ch]) begin
                char_rate_clock_out[ch] <= 1'b0;
            end else begin
                char_rate_clock_out[ch] <= char_tick || (bit_cnt < 4'h4);
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                primary_serial_out[ch]   <= 1'b0;
                secondary_serial_out[ch] <= 1'b0;
            end else begin
                primary_serial_out[ch]   <= drv_primary && shifter[0];
                secondary_serial_out[ch] <= drv_secondary && shifter[0];
            end
        end

        // ------------------------------------------------------
        // settling after re-enable
        always_ff @(posedge mclk) begin
            if (rst) begin
                powered_prev <= 1'b0;
                settle_cnt   <= 16'h0000;
            end else begin
                powered_prev <= powered[ch];
                if (powered[ch] && !powered_prev) begin
                    settle_cnt <= 16'(SETTLE_CYCLES);
                end else if (settle_cnt != 16'h0000) begin
                    settle_cnt <= settle_cnt - 16'h0001;
                end
            end
        end

        assign settling[ch] = settle_cnt != 16'h0000;
    end

endmodule : quad_video_tx_serializer_path
`default_nettype wire

// ### sim/quad_ser_sva.sv
// Purpose: port checks of the serializer path
// Assumes: one clock, rst active high
// Notes:   channel 0 carries the traffic
`timescale 1ns/1ps
`default_nettype none
module quad_ser_sva (
    // clock, reset, apb, interrupt
    input wire logic       mclk, rst, psel, penable, pready, pslverr, irq,
    // channel outputs
    input wire logic [3:0] phase_buffer_error, char_rate_clock_out,
    input wire logic [3:0] primary_serial_out, secondary_serial_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // assertions
    ready_high_a:
        assert property (pready) else $error("pready low");
    slverr_phase_a:
        assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    drivers_off_a:
        assert property ($fell(rst) |-> primary_serial_out == 4'h0
            && secondary_serial_out == 4'h0) else $error("driver on after reset");
    error_clear_a:
        assert property ($fell(rst) |-> phase_buffer_error == 4'h0 && !irq)
            else $error("error set after reset");
    error_hold_a:
        assert property ($rose(phase_buffer_error[0]) |=> phase_buffer_error[0] [*3])
            else $error("error not held");
    tick_width_a:
        assert property ($rose(char_rate_clock_out[0]) |=> char_rate_clock_out[0] [*3])
            else $error("char clock too short");
    tick_gap_a:
        assert property ($fell(char_rate_clock_out[0]) |-> !char_rate_clock_out[0] [*4])
            else $error("char clock gap too short");
    char_tail_a:
        assert property ($rose(char_rate_clock_out[0]) |-> ##13 !primary_serial_out[0]
            && !secondary_serial_out[0]) else $error("bits beyond ten");
    cover property ($rose(phase_buffer_error[0]));
    cover property ($rose(irq));
    cover property ($rose(secondary_serial_out[0]));
endmodule : quad_ser_sva
`default_nettype wire

// ### sim/video_source_model.sv
// Purpose: video coprocessor model, clocks and characters
// Assumes: reference period 20 mclk, full rate
// Notes:   drift shortens the input clock period
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
    // control
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            drift,
    input  wire logic      [9:0] char_val,
    // coprocessor pins
    output logic           [3:0] channel_reference_clock,
    output logic           [3:0] tx_input_clock,
    output logic      [3:0][9:0] tx_parallel_char_in
);
    int rc;
    int ic;
    // input clock locked to reference unless drift is commanded
    always_ff @(posedge mclk) begin
        rc <= (rst || rc == 19) ? 0 : rc + 1;
        ic <= (rst || ic == (drift ? 17 : 19)) ? 0 : ic + 1;
        channel_reference_clock <= {4{rc < 10}};
        tx_input_clock <= {4{ic < 10}};
        tx_parallel_char_in <= {4{char_val}};
    end
endmodule : video_source_model
`default_nettype wire

// ### sim/quad_video_tx_serializer_path_bench.sv
// Purpose: self-checking bench of the serializer path
// Assumes: settle count shortened to 20
// Notes:   apb reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
`include "quad_ser_regs.svh"
module quad_video_tx_serializer_path_bench;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, drift = 0, sec_on = 0;
    logic pready, pslverr, irq, config_write_strobe_n = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, exp_q[$];
    logic [3:0] config_addr = 4'h0, phase_buffer_error, char_rate_clock_out;
    logic [3:0] channel_reference_clock, tx_input_clock, primary_serial_out, secondary_serial_out;
    logic [4:0] config_data = 5'h00;
    logic [9:0] char_val = 10'h111, v;
    logic [3:0][9:0] tx_parallel_char_in;
    logic [15:0] seed = 16'h0055;
    int error_cnt = 0, n_compared = 0;
    always #20 mclk = ~mclk;
    quad_video_tx_serializer_path #(.SETTLE_CYCLES(20)) dut (.mclk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_write_strobe_n,
        .config_addr, .config_data, .channel_reference_clock, .tx_input_clock,
        .tx_parallel_char_in, .phase_buffer_error, .char_rate_clock_out,
        .primary_serial_out, .secondary_serial_out, .irq);
    video_source_model src (.mclk, .rst, .drift, .char_val, .channel_reference_clock,
        .tx_input_clock, .tx_parallel_char_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        s ^= s << 8;
        return s;
    endfunction : xs
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk); while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic cfg(input logic [3:0] b, input logic [4:0] d);
        apb(1'b1, 8'h0C, {23'h0, b, d});
    endtask : cfg
    task automatic grab(input int n);
        int z;
        z = 0;
        v = 10'h000;
        while (z < 4) begin
            @(posedge mclk);
            z = primary_serial_out[0] ? 0 : z + 1;
        end
        while (!primary_serial_out[0]) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            v[i] = primary_serial_out[0];
            @(posedge mclk);
        end
    endtask : grab
    always @(posedge mclk) begin
        sec_on <= sec_on | secondary_serial_out[0];
        if (psel && penable && pready && !pwrite) check(prdata, exp_q.pop_front());
        if (psel && penable && pready) check(32'(pslverr), 32'(paddr == 8'h40));
    end
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h40, 32'h0);
        seed = xs(seed);
        char_val <= seed[9:0] | 10'h111;
        cfg(4'h1, 5'h03);
        rd(8'h00, 32'h1100);
        repeat (200) @(posedge mclk);
        grab(10);
        check(32'(v), 32'(char_val));
        check(32'(sec_on), 32'h0);
        rd(8'h00, 32'h100);
        config_write_strobe_n <= 1'b0;
        config_addr <= 4'h0;
        config_data <= 5'h09;
        repeat (6) @(posedge mclk);
        config_write_strobe_n <= 1'b1;
        cfg(4'h1, 5'h07);
        // phase reset after switching to the input clock
        cfg(4'h2, 5'h01);
        cfg(4'h2, 5'h05);
        repeat (200) @(posedge mclk);
        grab(10);
        check(32'(v), 32'(char_val));
        drift <= 1'b1;
        while (!phase_buffer_error[0]) @(posedge mclk);
        check(32'(irq), 32'h0);
        rd(8'h04, 32'h1);
        grab(7);
        check(32'(v), `ERROR_CHAR >> 3);
        apb(1'b1, 8'h08, 32'h1);
        check(32'(irq), 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        check(32'(irq), 32'h0);
        rd(8'h00, 32'h101);
        drift <= 1'b0;
        cfg(4'h2, 5'h01);
        check(32'(phase_buffer_error), 32'h0);
        cfg(4'h2, 5'h07);
        rd(8'h00, 32'h110);
        end_sim();
    end
endmodule : quad_video_tx_serializer_path_bench
bind quad_video_tx_serializer_path quad_ser_sva chk (.mclk, .rst, .psel, .penable, .pready,
    .pslverr, .irq, .phase_buffer_error, .char_rate_clock_out, .primary_serial_out,
    .secondary_serial_out);
`default_nettype wire
